//--- core/bscn_unit.v
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bscn_map.vh"

module bscn_unit #(
   parameter CHAIN_W = 8,
   parameter ADDR_W  = 8
) (
   // clock and reset
   input  wire              ref_clk_i,
   input  wire              sys_rst_i,
   // test port pins
   input  wire              tck_i,
   input  wire              tms_i,
   input  wire              tdi_i,
   output reg               tdo_o,
   output reg               tdo_oe_n_o,
   output wire              bscan_tdo_sel_o,
   // combined debug port state
   input  wire              swd_mode_i,
   // security and startup
   input  wire              sec_bit_i,
   input  wire              startup_done_i,
   output wire              protected_o,
   // debugger path to the system bus
   input  wire              dbg_bus_req_i,
   output reg               dbg_bus_gnt_o,
   // device pins and core logic
   input  wire [CHAIN_W-1:0] pad_in_i,
   output wire [CHAIN_W-1:0] pad_out_o,
   output reg               pad_scan_o,
   input  wire [CHAIN_W-1:0] core_out_i,
   output wire [CHAIN_W-1:0] core_in_o,
   output reg               core_scan_o,
   // apb slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output wire              pready,
   output wire              pslverr
);

   // tap states, one-hot
   localparam [15:0] S_TLR  = 16'h0001;
   localparam [15:0] S_RTI  = 16'h0002;
   localparam [15:0] S_SDR  = 16'h0004;
   localparam [15:0] S_CDR  = 16'h0008;
   localparam [15:0] S_SHDR = 16'h0010;
   localparam [15:0] S_E1DR = 16'h0020;
   localparam [15:0] S_PDR  = 16'h0040;
   localparam [15:0] S_E2DR = 16'h0080;
   localparam [15:0] S_UDR  = 16'h0100;
   localparam [15:0] S_SIR  = 16'h0200;
   localparam [15:0] S_CIR  = 16'h0400;
   localparam [15:0] S_SHIR = 16'h0800;
   localparam [15:0] S_E1IR = 16'h1000;
   localparam [15:0] S_PIR  = 16'h2000;
   localparam [15:0] S_E2IR = 16'h4000;
   localparam [15:0] S_UIR  = 16'h8000;

   // instruction decode used in several places
   function is_chain;
      input [3:0] ir;
      begin
         is_chain = (ir == `BSCN_IR_EXTEST) || (ir == `BSCN_IR_SAMPLE) ||
                    (ir == `BSCN_IR_INTEST);
      end
   endfunction

   function is_known;
      input [3:0] ir;
      begin
         is_known = is_chain(ir) || (ir == `BSCN_IR_CLAMP);
      end
   endfunction

   function drives_pins;
      input [3:0] ir;
      begin
         drives_pins = (ir == `BSCN_IR_EXTEST) || (ir == `BSCN_IR_INTEST) ||
                       (ir == `BSCN_IR_CLAMP);
      end
   endfunction

   // link pins cross into the system clock
   wire [CHAIN_W+2:0] link_s;
   wire               tck_s;
   wire               tms_s;
   wire               tdi_s;
   wire [CHAIN_W-1:0] pad_s;

   bscn_sync #(
      .W (CHAIN_W + 3)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({pad_in_i, tdi_i, tms_i, tck_i}),
      .sync_o    (link_s)
   );

   assign tck_s = link_s[0];
   assign tms_s = link_s[1];
   assign tdi_s = link_s[2];
   assign pad_s = link_s[CHAIN_W+2:3];

   reg  tck_d_q;
   wire tck_rise;
   wire tck_fall;

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         tck_d_q <= 1'b0;
      end else begin
         tck_d_q <= tck_s;
      end
   end

   assign tck_rise = tck_s & ~tck_d_q;
   assign tck_fall = ~tck_s & tck_d_q;

   // tap controller
   reg  [15:0] state_q;
   reg  [15:0] state_d;

   always @* begin
      case (state_q)
         S_TLR:   state_d = tms_s ? S_TLR  : S_RTI;
         S_RTI:   state_d = tms_s ? S_SDR  : S_RTI;
         S_SDR:   state_d = tms_s ? S_SIR  : S_CDR;
         S_CDR:   state_d = tms_s ? S_E1DR : S_SHDR;
         S_SHDR:  state_d = tms_s ? S_E1DR : S_SHDR;
         S_E1DR:  state_d = tms_s ? S_UDR  : S_PDR;
         S_PDR:   state_d = tms_s ? S_E2DR : S_PDR;
         S_E2DR:  state_d = tms_s ? S_UDR  : S_SHDR;
         S_UDR:   state_d = tms_s ? S_SDR  : S_RTI;
         S_SIR:   state_d = tms_s ? S_TLR  : S_CIR;
         S_CIR:   state_d = tms_s ? S_E1IR : S_SHIR;
         S_SHIR:  state_d = tms_s ? S_E1IR : S_SHIR;
         S_E1IR:  state_d = tms_s ? S_UIR  : S_PIR;
         S_PIR:   state_d = tms_s ? S_E2IR : S_PIR;
         S_E2IR:  state_d = tms_s ? S_UIR  : S_SHIR;
         S_UIR:   state_d = tms_s ? S_SDR  : S_RTI;
         default: state_d = S_TLR;
      endcase
   end

   // serial-wire mode parks the controller so no instruction can load
   always @(posedge ref_clk_i) begin
      if (sys_rst_i || swd_mode_i) begin
         state_q <= S_TLR;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end

   // protected state, caught one cycle after reset release
   reg prot_q;
   reg prot_load_q;
   reg erase_req_q;

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         prot_q      <= `BSCN_PROT_RST;
         prot_load_q <= 1'b1;
      end else if (prot_load_q) begin
         prot_q      <= sec_bit_i;
         prot_load_q <= 1'b0;
      end else if (erase_req_q) begin
         prot_q      <= 1'b0;
      end
   end

   assign protected_o = prot_q;

   // lock stays closed until erase, or the load after reset, has cleared the state
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         dbg_bus_gnt_o <= 1'b0;
      end else begin
         dbg_bus_gnt_o <= dbg_bus_req_i & ~prot_q;
      end
   end

   // instruction path
   reg  [3:0] ir_sh_q;
   reg  [3:0] ir_q;
   wire [3:0] ir_cap;

   assign ir_cap[`BSCN_CAP_P_BIT] = prot_q;
   assign ir_cap[2:1]             = 2'b00;
   assign ir_cap[`BSCN_CAP_S_BIT] = (ir_q == `BSCN_IR_INTEST) ? 1'b1 : startup_done_i;

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ir_sh_q <= 4'h0;
      end else if (tck_rise) begin
         if (state_q == S_CIR) begin
            ir_sh_q <= ir_cap;
         end else if (state_q == S_SHIR) begin
            ir_sh_q <= {tdi_s, ir_sh_q[3:1]};
         end
      end
   end

   // update on the falling edge, as in the usual tap
   always @(posedge ref_clk_i) begin
      if (sys_rst_i || state_q == S_TLR) begin
         ir_q <= `BSCN_IR_RST;
      end else if (tck_fall && state_q == S_UIR) begin
         ir_q <= ir_sh_q;
      end
   end

   // data registers
   reg  [CHAIN_W-1:0] bsr_q;
   reg  [CHAIN_W-1:0] upd_q;
   reg                byp_q;
   wire               chain_sel;

   assign chain_sel = is_chain(ir_q);

   // a short shift leaves the high cells partly filled, which is allowed
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         bsr_q <= {CHAIN_W{1'b0}};
         byp_q <= 1'b0;
      end else if (tck_rise) begin
         if (state_q == S_CDR) begin
            byp_q <= 1'b0;
            if (ir_q == `BSCN_IR_INTEST) begin
               bsr_q <= core_out_i;
            end else if (chain_sel) begin
               bsr_q <= pad_s;
            end
         end else if (state_q == S_SHDR) begin
            if (chain_sel) begin
               bsr_q <= {tdi_s, bsr_q[CHAIN_W-1:1]};
            end else begin
               byp_q <= tdi_s;
            end
         end
      end
   end

   // sample/preload leaves the output latches untouched
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         upd_q <= {CHAIN_W{1'b0}};
      end else if (tck_fall && state_q == S_UDR) begin
         if (ir_q == `BSCN_IR_EXTEST || ir_q == `BSCN_IR_INTEST) begin
            upd_q <= bsr_q;
         end
      end
   end

   // pins and core inputs follow the latched chain once the instruction lands
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pad_scan_o  <= 1'b0;
         core_scan_o <= 1'b0;
      end else begin
         pad_scan_o  <= drives_pins(ir_q);
         core_scan_o <= (ir_q == `BSCN_IR_INTEST);
      end
   end

   assign pad_out_o = upd_q;
   assign core_in_o = upd_q;

   // serial output changes on the falling edge
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         tdo_o      <= 1'b0;
         tdo_oe_n_o <= 1'b1;
      end else if (tck_fall) begin
         if (state_q == S_SHIR) begin
            tdo_o      <= ir_sh_q[0];
            tdo_oe_n_o <= 1'b0;
         end else if (state_q == S_SHDR) begin
            tdo_o      <= chain_sel ? bsr_q[0] : byp_q;
            tdo_oe_n_o <= 1'b0;
         end else begin
            tdo_oe_n_o <= 1'b1;
         end
      end
   end

   assign bscan_tdo_sel_o = is_known(ir_q) & ~swd_mode_i;

   // apb slave, zero wait states
   wire apb_setup;
   wire apb_acc;
   wire hit_ctrl;
   wire hit_stat;
   wire hit_ir;
   wire hit_chain;
   wire hit_any;

   assign apb_setup = psel & ~penable;
   assign apb_acc   = psel & penable;
   assign hit_ctrl  = (paddr == `BSCN_CTRL_OFS);
   assign hit_stat  = (paddr == `BSCN_STAT_OFS);
   assign hit_ir    = (paddr == `BSCN_IR_OFS);
   assign hit_chain = (paddr == `BSCN_CHAIN_OFS);
   assign hit_any   = hit_ctrl | hit_stat | hit_ir | hit_chain;
   assign pready    = 1'b1;
   assign pslverr   = apb_acc & (~hit_any | (pwrite & ~hit_ctrl));

   // erase acts only at the access edge of a control write
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         erase_req_q <= 1'b0;
      end else begin
         erase_req_q <= apb_acc & pwrite & hit_ctrl & pwdata[`BSCN_CTRL_ERASE_BIT];
      end
   end

   reg [31:0] rd_d;

   always @* begin
      rd_d = 32'h0000_0000;
      if (hit_stat) begin
         rd_d[`BSCN_STAT_PROT_BIT]  = prot_q;
         rd_d[`BSCN_STAT_START_BIT] = startup_done_i;
         rd_d[`BSCN_STAT_SWD_BIT]   = swd_mode_i;
         rd_d[`BSCN_STAT_SEL_BIT]   = bscan_tdo_sel_o;
         rd_d[`BSCN_STAT_PINS_BIT]  = pad_scan_o;
         rd_d[`BSCN_STAT_CORE_BIT]  = core_scan_o;
      end else if (hit_ir) begin
         rd_d[3:0] = ir_q;
      end else if (hit_chain) begin
         rd_d[CHAIN_W-1:0] = upd_q;
      end
   end

   // read data latched in setup, stable through the access phase
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         prdata <= 32'h0000_0000;
      end else if (apb_setup) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_d;
      end
   end

endmodule

//--- core/bscn_map.vh
`ifndef BSCN_MAP_VH
`define BSCN_MAP_VH

// register byte offsets
`define BSCN_CTRL_OFS        8'h00
`define BSCN_STAT_OFS        8'h04
`define BSCN_IR_OFS          8'h08
`define BSCN_CHAIN_OFS       8'h0c

// control register fields
`define BSCN_CTRL_ERASE_BIT  0

// status register fields
`define BSCN_STAT_PROT_BIT   0
`define BSCN_STAT_START_BIT  1
`define BSCN_STAT_SWD_BIT    2
`define BSCN_STAT_SEL_BIT    3
`define BSCN_STAT_PINS_BIT   4
`define BSCN_STAT_CORE_BIT   5

// reset values
`define BSCN_PROT_RST        1'b1
`define BSCN_IR_RST          4'hf

// instruction codes
`define BSCN_IR_EXTEST       4'h0
`define BSCN_IR_SAMPLE       4'h1
`define BSCN_IR_INTEST       4'h4
`define BSCN_IR_CLAMP        4'h5
`define BSCN_IR_BYPASS       4'hf

// instruction capture pattern positions
`define BSCN_CAP_P_BIT       3
`define BSCN_CAP_S_BIT       0

// synchroniser depth in front of the link pins
`define BSCN_SYNC_STAGES     2

`endif

//--- core/bscn_sync.v
`timescale 1ns/1ps
`include "bscn_map.vh"

module bscn_sync #(
   parameter W = 1
) (
   // clock and reset
   input  wire         ref_clk_i,
   input  wire         sys_rst_i,
   // asynchronous levels in, synchronised levels out
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // first stage feeds only the second one
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

//--- verif/bscn_unit_asserts.sv
`timescale 1ns/1ps
module bscn_chk #(
   parameter ADDR_W = 8
) (
   // clock and reset
   input logic              ref_clk_i,
   input logic              sys_rst_i,
   // watched ports
   input logic              swd_mode_i,
   input logic              sec_bit_i,
   input logic              protected_o,
   input logic              dbg_bus_req_i,
   input logic              dbg_bus_gnt_o,
   input logic              bscan_tdo_sel_o,
   input logic              pad_scan_o,
   input logic              core_scan_o,
   input logic              psel,
   input logic              penable,
   input logic              pwrite,
   input logic [ADDR_W-1:0] paddr,
   input logic [31:0]       pwdata
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // erase writes seen lately; apart from the load after reset, an erase is the only way out of protection
   logic [3:0] ce_h_q;
   logic       ld_q;
   wire        ce_wr = psel && penable && pwrite && paddr == '0 && pwdata[0];
   always @(posedge ref_clk_i) begin
      ld_q   <= sys_rst_i;
      ce_h_q <= sys_rst_i ? 4'h0 : {ce_h_q[2:0], ce_wr};
   end
   a_prot_load: assert property ($past(ld_q) && !$past(sys_rst_i)
      |-> protected_o == $past(sec_bit_i)) else $error("bad protect load");
   a_bus_locked: assert property (protected_o |=> !dbg_bus_gnt_o)
      else $error("bus granted while protected");
   a_bus_open: assert property (!protected_o && dbg_bus_req_i |=> dbg_bus_gnt_o)
      else $error("bus not granted");
   a_erase_clears: assert property (ce_wr |-> ##[1:4] !protected_o)
      else $error("erase left protection");
   a_fall_cause: assert property ($fell(protected_o) && !$past(ld_q) |-> |ce_h_q)
      else $error("protection fell without erase");
   a_no_rise: assert property (!$rose(protected_o))
      else $error("protection rose before reset");
   a_swd_nosel: assert property (swd_mode_i |-> !bscan_tdo_sel_o)
      else $error("scan output selected in serial-wire mode");
   a_swd_exit_sel: assert property ($fell(swd_mode_i) && $past(swd_mode_i, 2)
      |-> !bscan_tdo_sel_o) else $error("scan output selected after serial-wire mode");
   a_swd_release: assert property (swd_mode_i [*4] |-> !pad_scan_o && !core_scan_o)
      else $error("pins held in serial-wire mode");
   a_intest_pads: assert property (core_scan_o |-> pad_scan_o)
      else $error("pads free under internal test");
   c_erase: cover property (ce_wr ##[1:4] !protected_o);
   c_intest: cover property ($rose(core_scan_o));
   c_swd: cover property (swd_mode_i [*4]);
endmodule

//--- verif/bscn_jtm.sv
`timescale 1ns/1ps
module bscn_jtm (
   // test port pins
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   input  logic tdo_i,
   input  logic tdo_oe_n_i
);
   logic do_q;
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
      do_q  = 1'b0;
   end
   // tck idles low between frames; undriven tdo reads as garbage
   task automatic step(input logic ms, input logic di, output logic dq);
      tms_o = ms;
      tdi_o = di;
      #100 tck_o = 1'b1;
      #99 dq = tdo_oe_n_i ? ~do_q : tdo_i;
      do_q = dq;
      tdi_o = ~di;
      #1 tck_o = 1'b0;
   endtask
   task automatic tlr();
      logic d;
      #7;
      repeat (5) step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
   endtask
   // idle to idle; odd offset keeps tck edges off the system clock edges
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic d;
      dout = '0;
      #7;
      step(1'b1, 1'b0, d);
      if (ir)
         step(1'b1, 1'b0, d);
      repeat (2) step(1'b0, 1'b0, d);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], d);
         dout[i] = d;
      end
      step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
   endtask
endmodule

//--- verif/bscn_unit_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module bscn_unit_tb_top;
   logic        ref_clk_i, sys_rst_i, tck_i, tms_i, tdi_i, swd_mode_i, sec_bit_i;
   logic        startup_done_i, dbg_bus_req_i, psel, penable, pwrite;
   logic        tdo_o, tdo_oe_n_o, bscan_tdo_sel_o, protected_o, dbg_bus_gnt_o;
   logic        pad_scan_o, core_scan_o, pready, pslverr;
   logic [7:0]  pad_in_i, pad_out_o, core_out_i, core_in_o, paddr, p, q, c;
   logic [31:0] pwdata, prdata, v, d, ob_v, exp_q[$];
   int          n_mismatch, cmp_count, seed = 42;
   event        ob_e;
   bscn_unit u_bscn_unit (.ref_clk_i, .sys_rst_i, .tck_i, .tms_i, .tdi_i, .tdo_o,
      .tdo_oe_n_o, .bscan_tdo_sel_o, .swd_mode_i, .sec_bit_i, .startup_done_i,
      .protected_o, .dbg_bus_req_i, .dbg_bus_gnt_o, .pad_in_i, .pad_out_o, .pad_scan_o,
      .core_out_i, .core_in_o, .core_scan_o, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   bscn_jtm u_bscn_jtm (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o),
      .tdo_oe_n_i(tdo_oe_n_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] a);
      logic [31:0] e;
      e = exp_q.pop_front();
      `CHK(a, e)
   endtask
   always @(posedge ref_clk_i) begin
      if (psel && penable && pready && !pwrite)
         cmp(prdata);
      // unmapped offsets, and writes anywhere but control, are refused
      if (psel && penable && pready)
         `CHK(pslverr, (paddr > 8'h0c) || (paddr[1:0] != 2'b00) || (pwrite && paddr != 8'h00))
   end
   always @(ob_e)
      cmp(ob_v);
   task automatic see(input logic [31:0] e, input logic [31:0] a);
      exp_q.push_back(e);
      ob_v = a;
      ->ob_e;
      #1;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk_i);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      do @(posedge ref_clk_i); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic ir(input logic [3:0] code, input logic [3:0] cap);
      u_bscn_jtm.scan(1'b1, 4, {28'h0, code}, v);
      see({28'h0, cap}, v);
   endtask
   task automatic dr(input int n, input logic [31:0] din, input logic [31:0] e);
      u_bscn_jtm.scan(1'b0, n, din, v);
      see(e, v);
   endtask
   initial begin
      {sys_rst_i, sec_bit_i, startup_done_i} = 3'h7;
      {swd_mode_i, dbg_bus_req_i, psel, penable, pwrite} = 5'h0;
      {pad_in_i, core_out_i, paddr, pwdata} = '0;
      repeat (4) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      dbg_bus_req_i <= 1'b1;
      rd(8'h04, 32'h03);
      rd(8'h08, 32'h0f);
      sec_bit_i <= 1'b0;
      rd(8'h04, 32'h03);
      u_bscn_jtm.tlr();
      ir(4'h0, 4'h9);
      rd(8'h04, 32'h1b);
      p = 8'($random(seed));
      pad_in_i <= p;
      d = $random(seed);
      dr(8, d, {24'h0, p});
      see({24'h0, d[7:0]}, {24'h0, pad_out_o});
      rd(8'h0c, {24'h0, d[7:0]});
      d = $random(seed);
      q = {d[2:0], p[7:3]};
      dr(3, d, {29'h0, p[2:0]});
      see({24'h0, q}, {24'h0, pad_out_o});
      rd(8'h0c, {24'h0, q});
      startup_done_i <= 1'b0;
      p = 8'($random(seed));
      pad_in_i <= p;
      ir(4'h1, 4'h8);
      dr(8, $random(seed), {24'h0, p});
      see({24'h0, q}, {24'h0, pad_out_o});
      ir(4'h4, 4'h8);
      ir(4'h4, 4'h9);
      rd(8'h04, 32'h39);
      c = 8'($random(seed));
      core_out_i <= c;
      d = $random(seed);
      dr(8, d, {24'h0, c});
      see({24'h0, d[7:0]}, {24'h0, core_in_o});
      ir(4'h5, 4'h9);
      dr(2, 32'h3, 32'h2);
      rd(8'h04, 32'h19);
      startup_done_i <= 1'b1;
      apb(1'b1, 8'h00, 32'h1);
      repeat (4) @(posedge ref_clk_i);
      rd(8'h04, 32'h1a);
      see(32'h1, {31'h0, dbg_bus_gnt_o});
      ir(4'hf, 4'h1);
      rd(8'h04, 32'h02);
      ir(4'h0, 4'h1);
      @(posedge ref_clk_i);
      swd_mode_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      rd(8'h08, 32'h0f);
      rd(8'h04, 32'h06);
      swd_mode_i <= 1'b0;
      u_bscn_jtm.tlr();
      ir(4'h0, 4'h1);
      u_bscn_jtm.tlr();
      rd(8'h04, 32'h02);
      rd(8'h10, 32'h0);
      apb(1'b1, 8'h04, 32'h0);
      sys_rst_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      rd(8'h04, 32'h02);
      give_verdict();
   end
   // generous ceiling: the whole sequence needs about 1300 cycles
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_mismatch++;
      give_verdict();
   end
endmodule
bind bscn_unit bscn_chk #(.ADDR_W(ADDR_W)) u_bscn_chk (.ref_clk_i, .sys_rst_i, .swd_mode_i,
   .sec_bit_i, .protected_o, .dbg_bus_req_i, .dbg_bus_gnt_o, .bscan_tdo_sel_o,
   .pad_scan_o, .core_scan_o, .psel, .penable, .pwrite, .paddr, .pwdata);
